// >>> verilog/isd_regs.vh
// Purpose: Offsets, field positions and constants for the interrupt split descriptor engine
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: Definitions only
`ifndef ISD_REGS_VH
`define ISD_REGS_VH

// ****************************************
// Register byte offsets
// ****************************************
`define ISD_OFF_DESC_LO 12'h000
`define ISD_OFF_DESC_HI 12'h004
`define ISD_OFF_CTRL 12'h008
`define ISD_OFF_STAT 12'h00C
`define ISD_OFF_IRQ_STAT 12'h010
`define ISD_OFF_IRQ_MASK 12'h014
`define ISD_OFF_DECODE 12'h018
`define ISD_OFF_LEN 12'h01C

// ****************************************
// Descriptor field positions (64-bit word) and the microframe field position
// ****************************************
`define ISD_VALID_BIT 0
`define ISD_XFER_LSB 3
`define ISD_XFER_MSB 17
`define ISD_PKT_LSB 18
`define ISD_PKT_MSB 28
`define ISD_EP0_BIT 31
`define ISD_EPHI_LSB 32
`define ISD_EPHI_MSB 34
`define ISD_FADDR_LSB 35
`define ISD_FADDR_MSB 41
`define ISD_TOKEN_LSB 42
`define ISD_TOKEN_MSB 43
`define ISD_KIND_LSB 44
`define ISD_KIND_MSB 45
`define ISD_SPLIT_BIT 46
`define ISD_SPEED_LSB 48
`define ISD_SPEED_MSB 49
`define ISD_PORT_LSB 50
`define ISD_PORT_MSB 56
`define ISD_ACTIVE_BIT 63
`define ISD_UFRM_LSB 3
`define ISD_UFRM_MSB 7

// ****************************************
// Encodings and limits
// ****************************************
`define ISD_TOKEN_OUT 2'h0
`define ISD_TOKEN_IN 2'h1
`define ISD_SPEED_FULL 2'h0
`define ISD_SPEED_LOW 2'h2
`define ISD_FSLS_PKT_MAX 11'h040
`define ISD_XFER_MAX 15'h1000
`define ISD_B_MIN 5'h04
`define ISD_B_MAX 5'h10

// ****************************************
// Control and interrupt bit positions
// ****************************************
`define ISD_CTRL_START 0
`define ISD_CTRL_ABORT 1
`define ISD_EV_DONE 0
`define ISD_EV_FATAL 1
`define ISD_EV_BADLEN 2
`define ISD_EV_BADTOK 3
`define ISD_EV_W 4

`endif

// >>> verilog/isd_period.v
// Purpose: Polling period decode from the microframe field
// Assumes: Field value is b, period is 2^(b-1) microframes
// Notes: Registered output, one cycle latency
`timescale 1ns/10ps
`include "isd_regs.vh"

module isd_period (
  input wire clock,
  input wire rstn,
  input wire ce,
  input wire [4:0] b_val,
  output reg [15:0] period_q,
  output reg period_ok_q
);

  wire in_range;
  wire [4:0] shift_amt;

  // Only b from 4 to 16 is defined; others give zero period
  assign in_range = (b_val >= `ISD_B_MIN) && (b_val <= `ISD_B_MAX);
  assign shift_amt = b_val - 5'h01;

  // Period in microframes, 2^(b-1)
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      period_q <= 16'h0000;
      period_ok_q <= 1'b0;
    end else if (ce) begin
      period_q <= in_range ? (16'h0001 << shift_amt[3:0]) : 16'h0000;
      period_ok_q <= in_range;
    end
  end

endmodule // isd_period

// >>> verilog/isd_core.v
// Purpose: Interrupt split descriptor decode and execution engine with APB access
// Assumes: Software loads the descriptor over APB, the link reports done and fatal
// Notes: One descriptor at a time; decoded fields drive the token issuing outputs
`timescale 1ns/10ps
`include "isd_regs.vh"

module isd_core (
  input wire clock,
  input wire rstn,
  input wire ce,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [7:0] ufrm_field,
  input wire link_done,
  input wire link_fatal,
  output reg tok_req_q,
  output reg tok_in_q,
  output reg tok_split_q,
  output reg tok_low_speed_q,
  output reg [6:0] hub_port_index_q,
  output reg [6:0] function_addr_q,
  output reg [3:0] endpoint_index_q,
  output reg [10:0] packet_size_limit_q,
  output reg [14:0] transfer_byte_total_q,
  output reg [15:0] poll_period_q,
  output reg irq_q
);

  // ****************************************
  // State encoding
  // ****************************************
  localparam ST_IDLE = 2'd0;
  localparam ST_RUN = 2'd1;
  localparam ST_WAIT = 2'd2;

  reg [31:0] desc_lo_q;
  reg [31:0] desc_hi_q;
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [`ISD_EV_W-1:0] irq_stat_q;
  reg [`ISD_EV_W-1:0] irq_mask_q;
  reg [`ISD_EV_W-1:0] ev;
  reg [31:0] rdata_d;
  reg map_hit;
  wire [63:0] desc;
  wire wr_acc;
  wire rd_acc;
  wire start_wr;
  wire abort_wr;
  wire [1:0] token;
  wire split;
  wire [1:0] speed;
  wire low_speed;
  wire pkt_bad;
  wire xfer_bad;
  wire tok_bad;
  wire [15:0] period_w;
  wire period_ok_w;

  // ****************************************
  // Field extraction
  // ****************************************
  // Reserved bits 2:1, 30:29, 47 and 62:57 are simply never read
  assign desc = {desc_hi_q, desc_lo_q};
  assign token = desc[`ISD_TOKEN_MSB:`ISD_TOKEN_LSB];
  assign split = desc[`ISD_SPLIT_BIT];
  assign speed = desc[`ISD_SPEED_MSB:`ISD_SPEED_LSB];
  // Speed code only matters for a split; full speed otherwise
  assign low_speed = split && (speed == `ISD_SPEED_LOW);
  assign tok_bad = (token != `ISD_TOKEN_OUT) && (token != `ISD_TOKEN_IN);
  // Full and low speed packets capped at 64 bytes
  assign pkt_bad = split &&
    (desc[`ISD_PKT_MSB:`ISD_PKT_LSB] > `ISD_FSLS_PKT_MAX);
  assign xfer_bad = desc[`ISD_XFER_MSB:`ISD_XFER_LSB] > `ISD_XFER_MAX;

  // ****************************************
  // Polling period decoder
  // ****************************************
  isd_period u_period (
    .clock(clock),
    .rstn(rstn),
    .ce(ce),
    .b_val(ufrm_field[`ISD_UFRM_MSB:`ISD_UFRM_LSB]),
    .period_q(period_w),
    .period_ok_q(period_ok_w)
  );

  // ****************************************
  // APB decode
  // ****************************************
  // Zero wait state: pready answers in the access phase itself
  assign wr_acc = psel && penable && pwrite && ce;
  assign rd_acc = psel && penable && !pwrite && ce;
  assign start_wr = wr_acc && (paddr == `ISD_OFF_CTRL) && pwdata[`ISD_CTRL_START];
  assign abort_wr = wr_acc && (paddr == `ISD_OFF_CTRL) && pwdata[`ISD_CTRL_ABORT];

  // Read mux and map hit
  always @* begin
    rdata_d = 32'h0000_0000;
    map_hit = 1'b1;
    case (paddr)
      `ISD_OFF_DESC_LO: rdata_d = desc_lo_q;
      `ISD_OFF_DESC_HI: rdata_d = desc_hi_q;
      `ISD_OFF_CTRL: rdata_d = 32'h0000_0000;
      `ISD_OFF_STAT: rdata_d = {28'h000_0000, period_ok_w, state_q, desc[`ISD_VALID_BIT]};
      `ISD_OFF_IRQ_STAT: rdata_d = {28'h000_0000, irq_stat_q};
      `ISD_OFF_IRQ_MASK: rdata_d = {28'h000_0000, irq_mask_q};
      `ISD_OFF_DECODE: rdata_d = {9'h000, hub_port_index_q, function_addr_q,
        endpoint_index_q, 2'h0, tok_low_speed_q, tok_split_q, tok_in_q};
      `ISD_OFF_LEN: rdata_d = {6'h00, packet_size_limit_q, transfer_byte_total_q};
      default: map_hit = 1'b0;
    endcase
  end

  // Bus answer registers; unmapped addresses report pslverr
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !map_hit;
      if (psel && !penable && !pwrite) begin
        prdata <= rdata_d;
      end
    end
  end

  // ****************************************
  // Sequencer
  // ****************************************
  // Next state: start needs valid set, ends on done, fatal or abort
  always @* begin
    state_d = state_q;
    ev = {`ISD_EV_W{1'b0}};
    case (state_q)
      ST_IDLE: begin
        if (start_wr && desc[`ISD_VALID_BIT]) begin
          if (tok_bad || pkt_bad || xfer_bad) begin
            ev[`ISD_EV_BADTOK] = tok_bad;
            ev[`ISD_EV_BADLEN] = pkt_bad || xfer_bad;
          end else begin
            state_d = ST_RUN;
          end
        end
      end
      ST_RUN: state_d = ST_WAIT;
      ST_WAIT: begin
        if (link_fatal || abort_wr) begin
          state_d = ST_IDLE;
          ev[`ISD_EV_FATAL] = 1'b1;
        end else if (link_done) begin
          state_d = ST_IDLE;
          ev[`ISD_EV_DONE] = 1'b1;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  // Descriptor storage; hardware clears valid and active on finish
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      desc_lo_q <= 32'h0000_0000;
      desc_hi_q <= 32'h0000_0000;
      state_q <= ST_IDLE;
    end else if (ce) begin
      state_q <= state_d;
      if (state_q == ST_WAIT && state_d == ST_IDLE) begin
        desc_lo_q[`ISD_VALID_BIT] <= 1'b0;
        desc_hi_q[`ISD_ACTIVE_BIT-32] <= 1'b0;
      end else if (state_q == ST_IDLE && wr_acc) begin
        // Descriptor locked while it executes, so fields stay stable
        if (paddr == `ISD_OFF_DESC_LO) begin
          desc_lo_q <= pwdata;
        end
        if (paddr == `ISD_OFF_DESC_HI) begin
          desc_hi_q <= pwdata;
        end
      end
    end
  end

  // ****************************************
  // Token issue outputs
  // ****************************************
  // Fields latched at launch, request held while waiting on link
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      tok_req_q <= 1'b0;
      tok_in_q <= 1'b0;
      tok_split_q <= 1'b0;
      tok_low_speed_q <= 1'b0;
      hub_port_index_q <= 7'h00;
      function_addr_q <= 7'h00;
      endpoint_index_q <= 4'h0;
      packet_size_limit_q <= 11'h000;
      transfer_byte_total_q <= 15'h0000;
      poll_period_q <= 16'h0000;
    end else if (ce) begin
      tok_req_q <= (state_d == ST_RUN) || (state_d == ST_WAIT);
      poll_period_q <= period_w;
      if (state_d == ST_RUN) begin
        tok_in_q <= (token == `ISD_TOKEN_IN);
        tok_split_q <= split;
        tok_low_speed_q <= low_speed;
        hub_port_index_q <= desc[`ISD_PORT_MSB:`ISD_PORT_LSB];
        function_addr_q <= desc[`ISD_FADDR_MSB:`ISD_FADDR_LSB];
        endpoint_index_q <= {desc[`ISD_EPHI_MSB:`ISD_EPHI_LSB], desc[`ISD_EP0_BIT]};
        packet_size_limit_q <= desc[`ISD_PKT_MSB:`ISD_PKT_LSB];
        transfer_byte_total_q <= desc[`ISD_XFER_MSB:`ISD_XFER_LSB];
      end
    end
  end

  // ****************************************
  // Interrupts
  // ****************************************
  // Sticky status, write one to clear; a new event beats the clear
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      irq_stat_q <= {`ISD_EV_W{1'b0}};
      irq_mask_q <= {`ISD_EV_W{1'b0}};
      irq_q <= 1'b0;
    end else if (ce) begin
      if (wr_acc && paddr == `ISD_OFF_IRQ_STAT) begin
        irq_stat_q <= (irq_stat_q & ~pwdata[`ISD_EV_W-1:0]) | ev;
      end else begin
        irq_stat_q <= irq_stat_q | ev;
      end
      if (wr_acc && paddr == `ISD_OFF_IRQ_MASK) begin
        irq_mask_q <= pwdata[`ISD_EV_W-1:0];
      end
      irq_q <= |(irq_stat_q & irq_mask_q);
    end
  end

endmodule // isd_core

// >>> sim/isd_checker.sv
// Purpose: Port assertions for the descriptor engine
// Assumes: ce high in this bench
// Notes: Descriptor words mirrored from APB writes
`timescale 1ns/10ps
module isd_checker (
  input wire clock,
  input wire rstn,
  input wire ce,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [7:0] ufrm_field,
  input wire link_done,
  input wire link_fatal,
  input wire tok_req_q,
  input wire tok_in_q,
  input wire tok_split_q,
  input wire tok_low_speed_q,
  input wire [6:0] hub_port_index_q,
  input wire [6:0] function_addr_q,
  input wire [3:0] endpoint_index_q,
  input wire [10:0] packet_size_limit_q,
  input wire [14:0] transfer_byte_total_q,
  input wire [15:0] poll_period_q
);
  logic [31:0] lo_q;
  logic [31:0] hi_q;
  logic [1:0] up_q;
  wire [4:0] b = ufrm_field[7:3];
  wire [15:0] per = (b >= 5'h04 && b <= 5'h10) ? 16'h0001 << (b - 5'h01) : 16'h0000;
  wire dw = psel && penable && pwrite && ce && !tok_req_q;
  wire ab = psel && paddr == 12'h008;
  // Mirror only idle writes, busy ones are dropped
  always_ff @(posedge clock) begin
    if (dw && paddr == 12'h000) lo_q <= pwdata;
    if (dw && paddr == 12'h004) hi_q <= pwdata;
  end
  // Settling count, the period pipe is stale just after reset
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) up_q <= 2'h0;
    else if (up_q != 2'h3) up_q <= up_q + 2'h1;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  sequence s_go; !tok_req_q ##1 tok_req_q; endsequence
  sequence s_end; tok_req_q && $past(tok_req_q) && ce && (link_done || link_fatal); endsequence
  property p_port; s_go |-> hub_port_index_q == hi_q[24:18]; endproperty
  property p_spl; s_go |-> tok_split_q == hi_q[14]; endproperty
  property p_low; s_go |-> tok_low_speed_q == (hi_q[14] && hi_q[17:16] == 2'h2); endproperty
  property p_in; s_go |-> tok_in_q == hi_q[10]; endproperty
  property p_adr; s_go |-> function_addr_q == hi_q[9:3]; endproperty
  property p_ep; s_go |-> endpoint_index_q == {hi_q[2:0], lo_q[31]}; endproperty
  property p_len; s_go |-> packet_size_limit_q == lo_q[28:18]
    && transfer_byte_total_q == lo_q[17:3]; endproperty
  property p_end; s_end |=> !tok_req_q; endproperty
  property p_hold; tok_req_q && !link_done && !link_fatal && !ab |=> tok_req_q; endproperty
  property p_per; up_q == 2'h3 && $stable(ufrm_field) [*3] |-> poll_period_q == per; endproperty
  a_port: assert property (p_port) else $error("hub port wrong");
  a_spl: assert property (p_spl) else $error("split flag wrong");
  a_low: assert property (p_low) else $error("speed decode wrong");
  a_in: assert property (p_in) else $error("token kind wrong");
  a_adr: assert property (p_adr) else $error("device address wrong");
  a_ep: assert property (p_ep) else $error("endpoint wrong");
  a_len: assert property (p_len) else $error("length fields wrong");
  a_end: assert property (p_end) else $error("request not ended");
  a_hold: assert property (p_hold) else $error("request ended early");
  a_per: assert property (p_per) else $error("poll period wrong");
endmodule // isd_checker

// >>> sim/isd_link_model.sv
// Purpose: Far-side hub or device answering a launched descriptor
// Assumes: Answer comes dly+1 cycles after the request rises
// Notes: fatal picks an error answer in place of completion
`timescale 1ns/10ps
module isd_link_model (
  input wire clock,
  input wire rstn,
  input wire tok_req_q,
  input wire [3:0] dly,
  input wire fatal,
  output logic link_done,
  output logic link_fatal
);
  logic [3:0] cnt_q;
  wire hit = tok_req_q && cnt_q >= dly;
  // Answer held until the request drops, as a slow device would
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= 4'h0;
      link_done <= 1'b0;
      link_fatal <= 1'b0;
    end else begin
      cnt_q <= tok_req_q ? cnt_q + {3'h0, cnt_q != 4'hf} : 4'h0;
      link_done <= hit && !fatal;
      link_fatal <= hit && fatal;
    end
  end
endmodule // isd_link_model

// >>> sim/interrupt_split_descriptor_test.sv
// Purpose: Self-checking bench for the descriptor engine
// Assumes: ce held high; far side is the link model
// Notes: Seeded random descriptors plus corner cases
`timescale 1ns/10ps
module interrupt_split_descriptor_test;
  logic clock, rstn, ce, psel, penable, pwrite, fatal, serr, s;
  logic [11:0] paddr;
  logic [31:0] pwdata, q;
  logic [7:0] ufrm_field;
  logic [3:0] dly, msk, e;
  wire [31:0] prdata;
  wire pready, pslverr, link_done, link_fatal, tok_req_q, tok_in_q, tok_split_q;
  wire tok_low_speed_q, irq_q;
  wire [6:0] hub_port_index_q, function_addr_q;
  wire [3:0] endpoint_index_q;
  wire [10:0] packet_size_limit_q;
  wire [14:0] transfer_byte_total_q;
  wire [15:0] poll_period_q;
  int n_errors, check_count;
  isd_core i_dut (.*);
  isd_link_model i_far (.*);
  // Free-running clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string n, input [63:0] x, input [63:0] g);
    check_count++;
    if (g !== x) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", n, x, g);
    end
  endtask
  // One APB transfer; waits for pready without assuming latency
  task automatic apb(input [11:0] a, input w, input [31:0] d);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clock);
      if (pready === 1'b1) break;
    end
    if (n == 20) n_errors++;
    // Pre-update values: what the slave showed at this very edge
    serr = pslverr;
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic await(input v);
    int n;
    for (n = 0; n < 60 && tok_req_q !== v; n++) @(negedge clock);
    if (n == 60) n_errors++;
  endtask
  // Legal layout, reserved bits left clear
  function automatic [63:0] mk(input [1:0] t, input sp, input [1:0] c, input [10:0] p,
      input [14:0] x);
    mk = 64'h0000_0000_0000_0001;
    mk[63] = 1'b1;
    {mk[56:50], mk[41:31]} = 18'($urandom);
    mk[49:48] = c;
    mk[46] = sp;
    mk[45:42] = {2'h3, t};
    mk[28:3] = {p, x};
  endfunction
  function automatic [63:0] dec(input [63:0] d);
    dec = {17'h0_0000, d[56:50], d[41:35], d[34:31], d[28:3], d[42], d[46],
      d[46] && d[49:48] == 2'h2};
  endfunction
  function automatic [3:0] ev(input [63:0] d, input [1:0] m);
    // Bad token and bad length may both be flagged at once
    ev = {d[43], (d[46] && d[28:18] > 11'h040) || d[17:3] > 15'h1000, 2'h0};
    if (ev == 4'h0) ev = m == 2'h0 ? 4'h1 : 4'h2;
  endfunction
  // Load, launch, finish and check one descriptor; m 0 done, 1 fatal, 2 abort
  task automatic run(input [63:0] d, input [1:0] m);
    e = ev(d, m);
    fatal <= m == 2'h1;
    dly <= m == 2'h2 ? 4'hf : 4'h2 + 4'($urandom % 6);
    apb(12'h000, 1'b1, d[31:0]);
    apb(12'h004, 1'b1, d[63:32]);
    apb(12'h008, 1'b1, 32'h0000_0001);
    if (e < 4'h4) begin
      await(1'b1);
      chk("fields", dec(d), {17'h0_0000, hub_port_index_q, function_addr_q, endpoint_index_q,
        packet_size_limit_q, transfer_byte_total_q, tok_in_q, tok_split_q, tok_low_speed_q});
      if (m == 2'h2) apb(12'h008, 1'b1, 32'h0000_0002);
      await(1'b0);
      apb(12'h000, 1'b0, 32'h0000_0000);
      chk("valid", 0, q[0]);
      apb(12'h004, 1'b0, 32'h0000_0000);
      chk("active", 0, q[31]);
      apb(12'h018, 1'b0, 32'h0000_0000);
      chk("decode", {9'h000, d[56:50], d[41:31], 2'h0, d[46] && d[49:48] == 2'h2,
        d[46], d[42]}, q);
      apb(12'h01c, 1'b0, 32'h0000_0000);
      chk("len", {6'h00, d[28:3]}, q);
    end else begin
      // Look after the launch edge has settled, not in its own time step
      @(negedge clock);
      chk("tok_req", 0, tok_req_q);
    end
    apb(12'h010, 1'b0, 32'h0000_0000);
    chk("irq_stat", e, q);
    @(negedge clock);
    chk("irq", |(e & msk), irq_q);
    apb(12'h010, 1'b1, {28'h000_0000, e});
  endtask
  // Main sequence
  initial begin
    {rstn, psel, penable, pwrite, fatal, ce} = 6'h01;
    {paddr, pwdata, ufrm_field, dly, msk} = {12'h000, 32'h0000_0000, 8'h00, 4'h2, 4'hf};
    void'($urandom(30217));
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    apb(12'h014, 1'b1, 32'h0000_000f);
    run(mk(2'h0, 1'b1, 2'h2, 11'h040, 15'h1000), 2'h0);
    run(mk(2'h1, 1'b1, 2'h0, 11'h041, 15'h0008), 2'h0);
    run(mk(2'h1, 1'b0, 2'h2, 11'h064, 15'h1001), 2'h0);
    run(mk(2'h2, 1'b0, 2'h0, 11'h008, 15'h0008), 2'h0);
    run(mk(2'h3, 1'b1, 2'h0, 11'h008, 15'h0008), 2'h0);
    run(mk(2'h1, 1'b0, 2'h2, 11'h200, 15'h0040), 2'h1);
    run(mk(2'h0, 1'b1, 2'h0, 11'h010, 15'h0010), 2'h2);
    $display("test corners ended");
    msk = 4'h0;
    apb(12'h014, 1'b1, 32'h0000_0000);
    run(mk(2'h1, 1'b1, 2'h2, 11'h008, 15'h0020), 2'h0);
    msk = 4'hf;
    apb(12'h014, 1'b1, 32'h0000_000f);
    $display("test mask ended");
    repeat (16) begin
      s = 1'($urandom);
      run(mk(2'($urandom % 2), s, {1'($urandom), 1'b0}, s ? 11'($urandom % 65) : 11'($urandom),
        15'($urandom % 4097)), 2'($urandom % 3));
    end
    $display("test random ended");
    apb(12'h020, 1'b0, 32'h0000_0000);
    chk("unmapped", {1'b1, 32'h0000_0000}, {serr, q});
    // Reset in mid-flight must drop the request and forget the descriptor
    fatal <= 1'b0;
    dly <= 4'hf;
    apb(12'h000, 1'b1, 32'h0000_0009);
    apb(12'h004, 1'b1, 32'h8000_0000);
    apb(12'h008, 1'b1, 32'h0000_0001);
    await(1'b1);
    @(posedge clock);
    rstn <= 1'b0;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    @(negedge clock);
    chk("reset outputs", 2'h0, {tok_req_q, irq_q});
    apb(12'h00c, 1'b0, 32'h0000_0000);
    chk("reset stat", 32'h0000_0000, q);
    $display("test reset ended");
    for (int b = 0; b < 32; b++) begin
      @(posedge clock);
      ufrm_field <= {5'(b), 3'($urandom)};
      repeat (3) @(posedge clock);
      @(negedge clock);
      chk("period", (b >= 4 && b <= 16) ? 64'h1 << (b - 1) : 64'h0, poll_period_q);
    end
    $display("test period ended");
    give_verdict;
  end
endmodule // interrupt_split_descriptor_test
bind isd_core isd_checker i_chk (.*);
